/* hw/wsw_watchdog_sleep_wake_ctrl.sv */
// Watchdog timer with sleep entry and wake-up control, APB register slave
// What this block does
// RQ1: Watchdog counts ticks of low-frequency internal oscillator
// RQ2: Reset loads control with select 0100, enable off
// RQ3: Sixteen-bit prescaler divides 32 up to 65536
// RQ4: Period select doubles ratio per code from 1:32
// RQ5: Software avoids reserved period select codes
// RQ6: Configuration enable forces watchdog on continuously
// RQ7: Otherwise software enable bit starts and stops it
// RQ8: Count cleared: disabled, clear instruction, osc fail, wake
// RQ9: Crystal modes hold count clear until start-up ends
// RQ10: Sleep clears count, watchdog keeps running
// RQ11: Sleep clears power-down flag, sets time-out flag
// RQ12: Sleep switches main oscillator driver off
// RQ13: Ports hold their drive state during sleep
// RQ14: Watchdog reset never drives master-clear pin low
// RQ15: Wake on master clear, watchdog, enabled interrupt
// RQ16: Watchdog wake clears time-out flag
// RQ17: Only listed asynchronous sources can wake
// RQ18: Sleep prefetches next; individual enable alone wakes
// RQ19: Global enable set branches to vector after next
// RQ20: Pending enabled flag during sleep wakes at once
// RQ21: Watchdog or interrupt wake clears the watchdog count; master clear wake leaves it
// RQ22: Interrupt entry pushes only return address
// RQ23: Already pending interrupt makes sleep a no-op
// RQ24: Start-up delay is 1024 periods, crystal only
// RQ25: Expiry resets when awake, wakes when asleep
// RQ26: Option register adds shared prescaler when assigned
`timescale 1ns/1ns
module wsw_watchdog_sleep_wake_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_freq_tick,
    input wire logic osc_period_tick,
    input wire logic config_watchdog_on,
    input wire logic crystal_mode,
    input wire logic osc_fail,
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic global_irq_enable,
    input wire logic [wsw_pkg::WSW_NUM_WAKE-1:0] wake_flags,
    input wire logic [wsw_pkg::WSW_NUM_WAKE-1:0] wake_enables,
    input wire logic master_clear_pin_n,
    input wire logic [7:0] port_out_in,
    input wire logic [7:0] port_oe_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    output logic master_clear_pin_out,
    output logic master_clear_pin_oe,
    output logic osc_driver_on,
    output logic sleeping,
    output logic prefetch_next,
    output logic wake_continue,
    output logic device_reset_req,
    output logic vector_req,
    output logic [12:0] vector_addr,
    output logic push_return_only,
    output logic timeout_flag_n,
    output logic powerdown_flag_n
);
    import wsw_pkg::*;

    // Registers
    logic [7:0] watchdog_control; // Period select and software enable
    logic [7:0] option_settings; // Shared prescaler assignment and rate
    logic [WSW_COUNT_W-1:0] wdt_count; // Prescaler plus watchdog count
    logic [10:0] ost_count; // Start-up periods seen
    wsw_state_e state; // Sleep sequencer
    wsw_state_e next_state;
    logic wake_by_irq; // Wake source was an interrupt

    // Field decode
    wire logic soft_watchdog_on = watchdog_control[WSW_SOFT_ON_BIT];
    wire logic [3:0] period_select = watchdog_control[WSW_PSEL_LSB +: 4];
    wire logic prescaler_assign = option_settings[WSW_PASSIGN_BIT];
    wire logic [2:0] prescaler_rate = option_settings[WSW_PRATE_LSB +: 3];

    // Watchdog enable: configuration wins over software bit
    wire logic wdt_enabled = config_watchdog_on | soft_watchdog_on; // [RQ6] [RQ7]

    // Reserved codes saturate at the longest legal ratio
    wire logic [3:0] psel_eff = (period_select > WSW_PSEL_MAX) ? WSW_PSEL_MAX : period_select; // [RQ5]
    // Total divide is 2^shift: 32 times 2^select, times shared prescaler when assigned
    wire logic [4:0] div_shift = WSW_PRESC_BASE_SHIFT + {1'b0, psel_eff}
        + (prescaler_assign ? {2'b00, prescaler_rate} : 5'h00); // [RQ3] [RQ4] [RQ26]
    wire logic [WSW_COUNT_W-1:0] wdt_term = WSW_COUNT_W'((25'h1 << div_shift) - 25'h1);

    // Expiry on the tick that completes the selected period
    wire logic wdt_expire = wdt_enabled & low_freq_tick & (wdt_count == wdt_term); // [RQ1]

    // Interrupt pending from an individually enabled source, regardless of global enable
    wire logic irq_pending = |(wake_flags & wake_enables); // [RQ17] [RQ18]

    // Sleep instruction taken only when nothing is pending
    wire logic sleep_nop = sleep_instr & (state == WSW_AWAKE) & irq_pending; // [RQ23]
    wire logic sleep_enter = sleep_instr & (state == WSW_AWAKE) & ~irq_pending; // [RQ10]

    // Wake events while asleep
    wire logic in_sleep = (state == WSW_ASLEEP);
    wire logic wake_wdt = in_sleep & wdt_expire; // [RQ15] [RQ25]
    wire logic wake_irq = in_sleep & irq_pending & ~wdt_expire; // [RQ20]
    wire logic wake_any = wake_wdt | wake_irq;
    wire logic master_clear_pin_reset = ~master_clear_pin_n;

    // Count clear conditions
    wire logic wdt_clear = ~wdt_enabled | watchdog_clear_instr | osc_fail | sleep_enter
        | wake_any | (state == WSW_OST_WAIT) | (state == WSW_WAKING) | wdt_expire; // [RQ8] [RQ9] [RQ21]

    // Start-up timer reaches its last period
    wire logic ost_done = osc_period_tick & (ost_count == WSW_OST_LAST); // [RQ24]

    // APB decode
    wire logic apb_setup = psel & ~penable;
    wire logic apb_write = psel & penable & pwrite;
    wire logic hit_ctrl = (paddr == WSW_ADDR_WDT_CTRL);
    wire logic hit_opt = (paddr == WSW_ADDR_OPTION);
    wire logic hit_stat = (paddr == WSW_ADDR_STATUS);
    wire logic hit_any = hit_ctrl | hit_opt | hit_stat;
    wire logic [7:0] status_view = {3'h0, ost_count != 11'h000, state == WSW_ASLEEP,
        wdt_enabled, timeout_flag_n, powerdown_flag_n};
    wire logic [7:0] read_mux = hit_ctrl ? watchdog_control : hit_opt ? option_settings
        : hit_stat ? status_view : 8'h00;

    // Zero wait state slave; error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // Read data captured in setup phase, stable through access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= {24'h00_0000, read_mux};
        end
    end

    // Control and option registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_control <= WSW_WDT_CTRL_RST; // [RQ2]
            option_settings <= WSW_OPTION_RST;
        end else begin
            // Unimplemented control bits stay zero; option register keeps all eight bits as written
            if (apb_write && hit_ctrl) begin
                watchdog_control <= pwdata[7:0] & WSW_WDT_CTRL_MASK;
            end
            if (apb_write && hit_opt) begin
                option_settings <= pwdata[7:0];
            end
        end
    end

    // Prescaler and watchdog counter on oscillator ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_count <= '0;
        end else if (wdt_clear) begin
            wdt_count <= '0; // [RQ8]
        end else if (low_freq_tick) begin
            wdt_count <= wdt_count + 24'h00_0001; // [RQ1]
        end
    end

    // Sleep sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            WSW_AWAKE: begin
                // Enter sleep unless an enabled interrupt is pending
                if (sleep_enter) begin
                    next_state = WSW_ASLEEP;
                end
            end
            WSW_ASLEEP: begin
                // Crystal modes wait for the start-up timer
                if (wake_any) begin
                    next_state = crystal_mode ? WSW_OST_WAIT : WSW_WAKING; // [RQ24]
                end
            end
            WSW_OST_WAIT: begin
                // Count stays clear until the last period
                if (ost_done) begin
                    next_state = WSW_WAKING; // [RQ9]
                end
            end
            WSW_WAKING: begin
                next_state = WSW_AWAKE;
            end
            default: begin
                next_state = WSW_AWAKE;
            end
        endcase
    end

    // Sleep sequencer state, master clear forces awake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= WSW_AWAKE;
        end else if (master_clear_pin_reset) begin
            state <= WSW_AWAKE; // [RQ15]
        end else begin
            state <= next_state;
        end
    end

    // Start-up period counter, only while waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_count <= 11'h000;
        end else if (state != WSW_OST_WAIT) begin
            ost_count <= 11'h000;
        end else if (osc_period_tick) begin
            ost_count <= ost_count + 11'h001; // [RQ24]
        end
    end

    // Remember the wake cause for the vector decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_by_irq <= 1'b0;
        end else if (wake_any) begin
            wake_by_irq <= wake_irq;
        end
    end

    // Status flags: set on power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1; // [RQ16]
        end else if (wdt_expire && state != WSW_OST_WAIT) begin
            timeout_flag_n <= 1'b0; // [RQ16] [RQ25]
        end else if (sleep_enter) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b0; // [RQ11]
        end else if (watchdog_clear_instr) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
    end

    // Core-facing pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prefetch_next <= 1'b0;
            wake_continue <= 1'b0;
            device_reset_req <= 1'b0;
            vector_req <= 1'b0;
            push_return_only <= 1'b0;
        end else begin
            prefetch_next <= sleep_enter; // [RQ18]
            wake_continue <= (state == WSW_WAKING); // [RQ15]
            device_reset_req <= (wdt_expire & (state == WSW_AWAKE)) | master_clear_pin_reset; // [RQ25]
            // Branch after the instruction following sleep
            vector_req <= wake_continue & wake_by_irq & global_irq_enable; // [RQ19]
            push_return_only <= wake_continue & wake_by_irq & global_irq_enable; // [RQ22]
        end
    end

    // Port drive: follows core while awake, frozen during sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_out <= 8'h00;
            port_oe <= 8'h00;
        end else if (state == WSW_AWAKE && !sleep_enter) begin
            port_out <= port_out_in; // [RQ13]
            port_oe <= port_oe_in;
        end
    end

    // Fixed outputs and sleep indications
    assign vector_addr = WSW_IRQ_VECTOR;
    assign master_clear_pin_out = 1'b0;
    assign master_clear_pin_oe = 1'b0; // [RQ14]
    assign sleeping = in_sleep;
    assign osc_driver_on = ~in_sleep; // [RQ12]

    // Assertions
    sequence sleep_taken_s;
        sleep_instr && state == WSW_AWAKE && !irq_pending && !wdt_expire;
    endsequence
    sequence sleep_settled_s;
        state == WSW_ASLEEP && !powerdown_flag_n && timeout_flag_n && wdt_count == '0;
    endsequence

    cfg_forces_on_a: assert property (@(posedge pclk) disable iff (!presetn || master_clear_pin_reset) // [RQ6]
        config_watchdog_on && low_freq_tick && state == WSW_AWAKE && !sleep_instr && !watchdog_clear_instr
        && !osc_fail && wdt_count != wdt_term |=> wdt_count != '0)
        else $error("watchdog not running with configuration enable");
    soft_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
        (!config_watchdog_on && !soft_watchdog_on) [*2] |-> wdt_count == '0 && !device_reset_req)
        else $error("stopped watchdog still counting");
    clear_instr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
        watchdog_clear_instr |=> wdt_count == '0)
        else $error("clear instruction did not clear count");
    sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn || master_clear_pin_reset) // [RQ11]
        sleep_taken_s |=> sleep_settled_s ##0 prefetch_next)
        else $error("sleep entry effects wrong");
    sleep_nop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
        sleep_nop && !wdt_expire && !watchdog_clear_instr |=> state == WSW_AWAKE && $stable(powerdown_flag_n)
        && $stable(timeout_flag_n))
        else $error("pending interrupt sleep not a no-op");
    osc_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
        state == WSW_ASLEEP |-> !osc_driver_on)
        else $error("oscillator driver on in sleep");
    port_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
        state == WSW_ASLEEP && $past(state) == WSW_ASLEEP |-> $stable(port_out) && $stable(port_oe))
        else $error("ports moved during sleep");
    master_clear_pin_free_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
        device_reset_req |-> !master_clear_pin_oe)
        else $error("master clear pin driven");
    wdt_wake_a: assert property (@(posedge pclk) disable iff (!presetn || master_clear_pin_reset) // [RQ16]
        wake_wdt |=> !timeout_flag_n && state != WSW_ASLEEP && wdt_count == '0)
        else $error("watchdog wake did not clear time-out flag");
    ost_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
        state == WSW_OST_WAIT |=> wdt_count == '0)
        else $error("count ran during start-up");
    ost_len_a: assert property (@(posedge pclk) disable iff (!presetn || master_clear_pin_reset) // [RQ24]
        state == WSW_OST_WAIT && ost_count != WSW_OST_LAST |=> state == WSW_OST_WAIT)
        else $error("start-up wait ended early");
    vector_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ19]
        wake_continue && wake_by_irq && global_irq_enable |=> vector_req && push_return_only)
        else $error("vector not requested after interrupt wake");
    awake_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ25]
        wdt_expire && state == WSW_AWAKE |=> device_reset_req && !timeout_flag_n)
        else $error("expiry while awake did not reset");
endmodule : wsw_watchdog_sleep_wake_ctrl

/* hw/wsw_pkg.sv */
// Shared constants for the watchdog, sleep and wake controller
package wsw_pkg;
    // Register indices (printed offsets) and their APB byte addresses
    localparam logic [11:0] WSW_IDX_WDT_CTRL = 12'h018;
    localparam logic [11:0] WSW_IDX_OPTION = 12'h081;
    localparam logic [11:0] WSW_IDX_STATUS = 12'h0C0;
    localparam logic [11:0] WSW_ADDR_WDT_CTRL = 12'(WSW_IDX_WDT_CTRL * 4);
    localparam logic [11:0] WSW_ADDR_OPTION = 12'(WSW_IDX_OPTION * 4);
    localparam logic [11:0] WSW_ADDR_STATUS = 12'(WSW_IDX_STATUS * 4);
    // Values after reset, and the control write mask
    localparam logic [7:0] WSW_WDT_CTRL_RST = 8'h08;
    localparam logic [7:0] WSW_OPTION_RST = 8'hFF;
    localparam logic [7:0] WSW_WDT_CTRL_MASK = 8'h1F;
    // Field positions
    localparam int WSW_SOFT_ON_BIT = 0;
    localparam int WSW_PSEL_LSB = 1;
    localparam int WSW_PRATE_LSB = 0;
    localparam int WSW_PASSIGN_BIT = 3;
    // Prescaler shaping
    localparam logic [4:0] WSW_PRESC_BASE_SHIFT = 5'h05;
    localparam logic [3:0] WSW_PSEL_MAX = 4'hB;
    localparam int WSW_COUNT_W = 24;
    // Time base and start-up delay
    localparam int WSW_LFO_FREQ_KHZ = 31;
    localparam int WSW_PCLK_FREQ_KHZ = 50000;
    localparam int WSW_OST_PERIODS = 1024;
    localparam logic [10:0] WSW_OST_LAST = 11'(WSW_OST_PERIODS - 1);
    // Interrupt vector and wake sources
    localparam logic [12:0] WSW_IRQ_VECTOR = 13'h0004;
    localparam int WSW_NUM_WAKE = 6;
    // Sleep state machine, Gray coded along awake-sleep-wait-wake
    typedef enum logic [1:0] {
        WSW_AWAKE = 2'b00,
        WSW_ASLEEP = 2'b01,
        WSW_OST_WAIT = 2'b11,
        WSW_WAKING = 2'b10
    } wsw_state_e;
endpackage : wsw_pkg

/* sim/wsw_core_model.sv */
// Processor core stand-in that issues instructions and counts resumes
`timescale 1ns/1ns
module wsw_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wake_continue,
    input wire logic vector_req,
    output logic sleep_instr,
    output logic watchdog_clear_instr,
    output logic [7:0] port_out_in,
    output logic [7:0] port_oe_in,
    output int resumes,
    output int vectors
);
    // Instruction strobes idle low from time zero
    initial begin
        sleep_instr = 1'b0;
        watchdog_clear_instr = 1'b0;
    end
    // One-cycle sleep or watchdog-clear strobe, raised just after an edge
    task automatic issue(input logic is_sleep);
        @(posedge pclk);
        sleep_instr <= is_sleep;
        watchdog_clear_instr <= !is_sleep;
        @(posedge pclk);
        sleep_instr <= 1'b0;
        watchdog_clear_instr <= 1'b0;
    endtask : issue
    // Port drive keeps moving even in sleep, so a frozen output shows
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_out_in <= 8'h00;
            port_oe_in <= 8'hFF;
            resumes <= 0;
            vectors <= 0;
        end else begin
            port_out_in <= port_out_in + 8'h01;
            port_oe_in <= ~port_out_in;
            // Resume and vector fetches seen by the core
            resumes <= resumes + int'(wake_continue === 1'b1);
            vectors <= vectors + int'(vector_req === 1'b1);
        end
    end
endmodule : wsw_core_model

/* sim/tb_top.sv */
// Self-checking bench for the watchdog, sleep and wake controller
`timescale 1ns/1ns
module tb_top;
    import wsw_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic pready, pslverr, rd_e, low_freq_tick = 1'b0, osc_period_tick = 1'b0, config_watchdog_on = 1'b0;
    logic crystal_mode = 1'b0, osc_fail = 1'b0, global_irq_enable = 1'b0, master_clear_pin_n = 1'b1;
    logic [5:0] wake_flags = 6'h00, wake_enables = 6'h00;
    logic sleep_instr, watchdog_clear_instr, master_clear_pin_out, master_clear_pin_oe, osc_driver_on, sleeping;
    logic prefetch_next, wake_continue, device_reset_req, vector_req, push_return_only, timeout_flag_n;
    logic powerdown_flag_n;
    logic [7:0] port_out_in, port_oe_in, port_out, port_oe;
    logic [15:0] snap;
    logic [12:0] vector_addr;
    int err_count = 0, samples_checked = 0, rst_cnt = 0, pf_cnt = 0, push_cnt = 0, resumes, vectors, n;
    // Expiry cases: control value, option value, ticks to expiry
    logic [7:0] cv [3] = '{8'h01, 8'h03, 8'h01};
    logic [7:0] ov [3] = '{8'h00, 8'h00, 8'h09};
    int tk [3] = '{32, 64, 64};

    wsw_watchdog_sleep_wake_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_freq_tick(low_freq_tick), .osc_period_tick(osc_period_tick), .config_watchdog_on(config_watchdog_on),
        .crystal_mode(crystal_mode), .osc_fail(osc_fail), .sleep_instr(sleep_instr),
        .watchdog_clear_instr(watchdog_clear_instr), .global_irq_enable(global_irq_enable),
        .wake_flags(wake_flags), .wake_enables(wake_enables), .master_clear_pin_n(master_clear_pin_n),
        .port_out_in(port_out_in), .port_oe_in(port_oe_in), .port_out(port_out), .port_oe(port_oe),
        .master_clear_pin_out(master_clear_pin_out), .master_clear_pin_oe(master_clear_pin_oe),
        .osc_driver_on(osc_driver_on), .sleeping(sleeping), .prefetch_next(prefetch_next),
        .wake_continue(wake_continue), .device_reset_req(device_reset_req), .vector_req(vector_req),
        .vector_addr(vector_addr), .push_return_only(push_return_only), .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n));
    wsw_core_model i_core (.pclk(pclk), .presetn(presetn), .wake_continue(wake_continue),
        .vector_req(vector_req), .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
        .port_out_in(port_out_in), .port_oe_in(port_oe_in), .resumes(resumes), .vectors(vectors));

    // Free-running 50 MHz clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    // Pulse counters for reset requests, prefetches and return pushes
    always @(posedge pclk) begin
        rst_cnt <= rst_cnt + int'(device_reset_req === 1'b1);
        pf_cnt <= pf_cnt + int'(prefetch_next === 1'b1);
        push_cnt <= push_cnt + int'(push_return_only === 1'b1);
    end
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) begin
            err_count++;
            results();
        end
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, exp);
    endtask : rdc
    // Low-frequency oscillator ticks, one every second cycle
    task automatic lf(input int k);
        repeat (k) begin
            @(posedge pclk);
            low_freq_tick <= ~low_freq_tick;
            @(posedge pclk);
            low_freq_tick <= ~low_freq_tick;
        end
    endtask : lf
    // Clock mode, global interrupt enable and configuration enable together
    task automatic mode(input logic x, input logic g, input logic c);
        crystal_mode <= x;
        global_irq_enable <= g;
        config_watchdog_on <= c;
    endtask : mode
    // Clear, then expect expiry on exactly the k-th tick
    task automatic expire(input int k);
        int r;
        r = rst_cnt;
        i_core.issue(1'b0);
        lf(k - 1);
        cyc(3);
        chk("early expiry", rst_cnt, r);
        lf(1);
        cyc(3);
        chk("expiry reset", rst_cnt, r + 1);
    endtask : expire

    // Main sequence
    initial begin
        cyc(3);
        presetn <= 1'b1;
        rdc("ctrl reset", WSW_ADDR_WDT_CTRL, 32'h08);
        rdc("option reset", WSW_ADDR_OPTION, 32'hFF);
        rdc("status reset", WSW_ADDR_STATUS, 32'h03);
        apb(1'b0, 12'h004, 32'h0);
        chk("unmapped", {rd_e, rd_v[30:0]}, 32'h80000000);
        // Highest non-reserved code only
        apb(1'b1, WSW_ADDR_WDT_CTRL, 32'hF7);
        rdc("ctrl mask", WSW_ADDR_WDT_CTRL, 32'h17);
        apb(1'b1, WSW_ADDR_STATUS, 32'h0);
        rdc("status ro", WSW_ADDR_STATUS, 32'h07);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, WSW_ADDR_WDT_CTRL, {24'h0, cv[i]});
            apb(1'b1, WSW_ADDR_OPTION, {24'h0, ov[i]});
            expire(tk[i]);
        end
        chk("expiry flags", {timeout_flag_n, master_clear_pin_oe}, 32'h0);
        apb(1'b1, WSW_ADDR_OPTION, 32'h0);
        // Clear instruction and oscillator failure restart the count
        n = rst_cnt;
        i_core.issue(1'b0);
        lf(20);
        i_core.issue(1'b0);
        lf(20);
        osc_fail <= ~osc_fail;
        cyc(1);
        osc_fail <= ~osc_fail;
        lf(20);
        cyc(3);
        chk("count cleared", rst_cnt, n);
        // Sleep with the watchdog running, woken by expiry
        i_core.issue(1'b1);
        cyc(3);
        chk("asleep", {sleeping, osc_driver_on, powerdown_flag_n, timeout_flag_n}, 32'h9);
        chk("prefetch", pf_cnt, 1);
        snap = {port_oe, port_out};
        cyc(4);
        chk("port hold", {port_oe, port_out}, snap);
        lf(31);
        cyc(3);
        chk("still asleep", sleeping, 1);
        n = rst_cnt;
        lf(1);
        cyc(5);
        chk("wdt wake", {sleeping, timeout_flag_n, powerdown_flag_n, 29'(resumes), 1'b0}, 32'h2);
        chk("no reset", rst_cnt, n);
        // Interrupt wake through the start-up delay, global enable set
        mode(1'b1, 1'b1, 1'b0);
        i_core.issue(1'b1);
        cyc(2);
        wake_enables <= 6'h04;
        wake_flags <= 6'h04;
        osc_period_tick <= ~osc_period_tick;
        cyc(1);
        apb(1'b0, WSW_ADDR_STATUS, 32'h0);
        chk("startup counting", rd_v[4], 1);
        cyc(1020);
        chk("startup hold", resumes, 1);
        n = 0;
        while (resumes == 1 && n < 100) begin
            cyc(1);
            n++;
        end
        osc_period_tick <= ~osc_period_tick;
        chk("startup length", {resumes, 1'b0} + (n >= 4 && n <= 8), 5);
        cyc(3);
        chk("vector", {8'(vectors), 8'(push_cnt), 16'(vector_addr)}, 32'h0101_0004);
        chk("irq wake flags", {timeout_flag_n, powerdown_flag_n}, 32'h2);
        // Enabled flag already pending makes sleep a no-op
        mode(1'b0, 1'b0, 1'b0);
        i_core.issue(1'b0);
        i_core.issue(1'b1);
        cyc(3);
        chk("sleep nop", {sleeping, powerdown_flag_n}, 32'h1);
        // Every wake source needs its own enable, checked with the global enable clear
        for (int i = 0; i < 6; i++) begin
            wake_enables <= 6'h00;
            wake_flags <= 6'(1 << i);
            i_core.issue(1'b1);
            cyc(4);
            chk("masked stays", sleeping, 1);
            wake_enables <= 6'(1 << i);
            cyc(6);
            chk("source wakes", sleeping, 0);
        end
        chk("inline resume", {16'(resumes), 16'(vectors)}, 32'h0008_0001);
        // Master clear during sleep resets without the pin being driven
        wake_flags <= 6'h00;
        wake_enables <= 6'h00;
        i_core.issue(1'b1);
        cyc(3);
        n = rst_cnt;
        master_clear_pin_n <= ~master_clear_pin_n;
        cyc(3);
        master_clear_pin_n <= ~master_clear_pin_n;
        cyc(2);
        chk("master_clear_pin wake", {sleeping, master_clear_pin_oe, master_clear_pin_out, 1'b0} + (rst_cnt > n), 1);
        // Configuration enable overrides the software bit
        apb(1'b1, WSW_ADDR_WDT_CTRL, 32'h0);
        mode(1'b0, 1'b0, 1'b1);
        apb(1'b0, WSW_ADDR_STATUS, 32'h0);
        chk("forced on", rd_v[2], 1);
        expire(32);
        mode(1'b0, 1'b0, 1'b0);
        n = rst_cnt;
        i_core.issue(1'b0);
        lf(40);
        cyc(3);
        chk("soft off", rst_cnt, n);
        results();
    end
endmodule : tb_top
